// >>> common/cpuadd_params.svh
// constants for the add-instruction execution core
`ifndef CPUADD_PARAMS_SVH
`define CPUADD_PARAMS_SVH
`define CPUADD_OP_ADD_LITERAL_INSTR 8'h0f
`define CPUADD_OP_ADD_FILE_REGISTER_INSTR 6'h09
`define CPUADD_OP_GOTO 8'hef
`define CPUADD_OP_BRA 5'h1a
`define CPUADD_OP_BZ 8'he0
`define CPUADD_OP_BNZ 8'he1
`define CPUADD_OP_MOVLB 12'h010
`define CPUADD_OP_TBLWT 14'h0003
`define CPUADD_OP_SECOND 4'hf
`define CPUADD_NOP_WORD 16'h0000
`define CPUADD_ACCESS_SPLIT 8'h80
`define CPUADD_ACCESS_HI 4'hf
`define CPUADD_PORT_B_ADDR 12'hf81
`define CPUADD_TIMER0_ADDR 12'hfd6
`define CPUADD_REG_CTRL 2'h0
`define CPUADD_REG_WREG 2'h1
`define CPUADD_REG_STATUS 2'h2
`define CPUADD_REG_PCLO 2'h3
`define CPUADD_CTRL_RST 1'b1
`define CPUADD_PC_RST 21'h000000
`define CPUADD_PC_STEP 21'h000002
`endif

// >>> common/cpuadd_pkg.sv
// types for the add-instruction execution core
`default_nettype none
package cpuadd_pkg;
    typedef enum logic [1:0] {
        CPUADD_Q1 = 2'b00,
        CPUADD_Q2 = 2'b01,
        CPUADD_Q3 = 2'b10,
        CPUADD_Q4 = 2'b11
    } cpuadd_phase_t;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } cpuadd_status_t;

    typedef struct packed {
        cpuadd_phase_t q;
        logic run;
        logic [20:0] pc;
        logic [15:0] ir;
        logic [7:0] w;
        logic [3:0] bank_select_register;
        cpuadd_status_t st;
        logic [7:0] opnd;
        logic [7:0] res;
        cpuadd_status_t nflg;
        logic [11:0] dm_addr;
        logic [7:0] dm_wdata;
        logic dm_we;
        logic pre_clr;
        logic tw_busy;
        logic [7:0] rdata;
    } cpuadd_state_t;
endpackage
`default_nettype wire

// >>> core/cpuadd_core.sv
// four-phase execution core for the add instructions and flow-control notes
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cpuadd_params.svh"

module cpuadd_core
    import cpuadd_pkg::*;
#(
    parameter logic [11:0] PORT_B_ADDR = `CPUADD_PORT_B_ADDR,
    parameter logic [11:0] TIMER0_ADDR = `CPUADD_TIMER0_ADDR
)
(
    input wire logic ref_clk,
    input wire logic rst,
    output logic [20:0] pm_addr,
    input wire logic [15:0] pm_rdata,
    output logic [11:0] dm_addr,
    input wire logic [7:0] dm_rdata,
    output logic [7:0] dm_wdata,
    output logic dm_we,
    input wire logic [7:0] port_b_pins,
    input wire logic prescaler_assigned,
    output logic prescaler_clr,
    input wire logic tw_done,
    output logic tw_busy,
    output logic q1_phase,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata
);

    cpuadd_state_t s_r;
    cpuadd_state_t s_nxt;

    logic is_add_literal_instr;
    logic is_add_file_register_instr;
    logic is_goto;
    logic is_bra;
    logic is_bz;
    logic is_bnz;
    logic is_movlb;
    logic is_tblwt;
    logic dest_file;
    logic [11:0] fa;
    logic [7:0] b_opnd;
    logic [8:0] sum9;
    logic [4:0] sum_lo;
    logic [20:0] bra_off;
    logic [20:0] bz_off;

    // decode straight from the instruction register; any unlisted word is a no-op
    always_comb
    begin
        is_add_literal_instr = (s_r.ir[15:8] == `CPUADD_OP_ADD_LITERAL_INSTR);
        is_add_file_register_instr = (s_r.ir[15:10] == `CPUADD_OP_ADD_FILE_REGISTER_INSTR);
        is_goto = (s_r.ir[15:8] == `CPUADD_OP_GOTO);
        is_bra = (s_r.ir[15:11] == `CPUADD_OP_BRA);
        is_bz = (s_r.ir[15:8] == `CPUADD_OP_BZ);
        is_bnz = (s_r.ir[15:8] == `CPUADD_OP_BNZ);
        is_movlb = (s_r.ir[15:4] == `CPUADD_OP_MOVLB);
        is_tblwt = (s_r.ir[15:2] == `CPUADD_OP_TBLWT);
        // a word starting with the second-word code matches nothing above
        if (s_r.ir[15:12] == `CPUADD_OP_SECOND)
        begin
            is_goto = 1'b0;
        end
        dest_file = is_add_file_register_instr & s_r.ir[9];
        if (s_r.ir[8])
        begin
            fa = {s_r.bank_select_register, s_r.ir[7:0]};
        end
        else if (s_r.ir[7:0] < `CPUADD_ACCESS_SPLIT)
        begin
            fa = {4'h0, s_r.ir[7:0]};
        end
        else
        begin
            fa = {`CPUADD_ACCESS_HI, s_r.ir[7:0]};
        end
        bra_off = {{9{s_r.ir[10]}}, s_r.ir[10:0], 1'b0};
        bz_off = {{12{s_r.ir[7]}}, s_r.ir[7:0], 1'b0};
    end

    // operand source: pins when a port is rewritten from itself
    always_comb
    begin
        if (is_add_literal_instr)
        begin
            b_opnd = s_r.ir[7:0];
        end
        else if (dest_file && (fa == PORT_B_ADDR))
        begin
            b_opnd = port_b_pins;
        end
        else
        begin
            b_opnd = dm_rdata;
        end
    end

    always_comb
    begin
        sum9 = {1'b0, s_r.w} + {1'b0, s_r.opnd};
        sum_lo = {1'b0, s_r.w[3:0]} + {1'b0, s_r.opnd[3:0]};
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.dm_we = 1'b0;
        s_nxt.pre_clr = 1'b0;
        // register port
        if (reg_we && (reg_addr == `CPUADD_REG_CTRL))
        begin
            s_nxt.run = reg_wdata[0];
        end
        if (reg_re)
        begin
            if (reg_addr == `CPUADD_REG_CTRL)
            begin
                s_nxt.rdata = {7'h00, s_r.run};
            end
            else if (reg_addr == `CPUADD_REG_WREG)
            begin
                s_nxt.rdata = s_r.w;
            end
            else if (reg_addr == `CPUADD_REG_STATUS)
            begin
                s_nxt.rdata = {3'h0, s_r.st};
            end
            else
            begin
                s_nxt.rdata = s_r.pc[7:0];
            end
        end
        // table write busy ends only on its own termination; nothing here aborts it
        if (s_r.tw_busy && tw_done)
        begin
            s_nxt.tw_busy = 1'b0;
        end
        case (s_r.q)
            CPUADD_Q1:
            begin
                // decode; a halted core parks here at a cycle boundary
                if (s_r.run)
                begin
                    s_nxt.q = CPUADD_Q2;
                    s_nxt.dm_addr = fa;
                end
            end
            CPUADD_Q2:
            begin
                s_nxt.q = CPUADD_Q3;
                s_nxt.opnd = b_opnd;
            end
            CPUADD_Q3:
            begin
                s_nxt.q = CPUADD_Q4;
                s_nxt.res = sum9[7:0];
                s_nxt.nflg.c = sum9[8];
                s_nxt.nflg.dc = sum_lo[4];
                s_nxt.nflg.z = (sum9[7:0] == 8'h00);
                s_nxt.nflg.n = sum9[7];
                s_nxt.nflg.ov = (s_r.w[7] == s_r.opnd[7]) && (sum9[7] != s_r.w[7]);
                if (dest_file)
                begin
                    s_nxt.dm_we = 1'b1;
                    s_nxt.dm_wdata = sum9[7:0];
                    if ((fa == TIMER0_ADDR) && prescaler_assigned)
                    begin
                        s_nxt.pre_clr = 1'b1;
                    end
                end
            end
            CPUADD_Q4:
            begin
                s_nxt.q = CPUADD_Q1;
                s_nxt.pc = s_r.pc + `CPUADD_PC_STEP;
                s_nxt.ir = pm_rdata;
                if (is_add_literal_instr || is_add_file_register_instr)
                begin
                    s_nxt.st = s_r.nflg;
                    if (!dest_file)
                    begin
                        s_nxt.w = s_r.res;
                    end
                end
                if (is_movlb)
                begin
                    s_nxt.bank_select_register = s_r.ir[3:0];
                end
                if (is_tblwt && !s_r.tw_busy)
                begin
                    s_nxt.tw_busy = 1'b1;
                end
                // the word fetched beside a two-word jump is its operand
                if (is_goto)
                begin
                    s_nxt.pc = {pm_rdata[11:0], s_r.ir[7:0], 1'b0};
                    s_nxt.ir = `CPUADD_NOP_WORD;
                end
                else if (is_bra)
                begin
                    s_nxt.pc = s_r.pc + bra_off;
                    s_nxt.ir = `CPUADD_NOP_WORD;
                end
                else if ((is_bz && s_r.st.z) || (is_bnz && !s_r.st.z))
                begin
                    s_nxt.pc = s_r.pc + bz_off;
                    s_nxt.ir = `CPUADD_NOP_WORD;
                end
            end
            default:
            begin
                s_nxt.q = CPUADD_Q1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.run <= `CPUADD_CTRL_RST;
            s_r.pc <= `CPUADD_PC_RST;
            s_r.ir <= `CPUADD_NOP_WORD;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // pc always names the word being fetched during the current cycle
    assign pm_addr = s_r.pc;
    assign dm_addr = s_r.dm_addr;
    assign dm_wdata = s_r.dm_wdata;
    assign dm_we = s_r.dm_we;
    assign prescaler_clr = s_r.pre_clr;
    assign tw_busy = s_r.tw_busy;
    assign q1_phase = (s_r.q == CPUADD_Q1);
    assign reg_rdata = s_r.rdata;

endmodule
`default_nettype wire

// >>> dv/cpuadd_core_properties.sv
// port assertions for the add-execution core
`timescale 1ns/1ps
`default_nettype none
module cpuadd_core_properties
    import cpuadd_pkg::*;
#(
    parameter logic [11:0] TIMER0_ADDR = 12'hfd6
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [20:0] pm_addr,
    input wire logic [11:0] dm_addr,
    input wire logic dm_we,
    input wire logic prescaler_assigned,
    input wire logic prescaler_clr,
    input wire logic tw_done,
    input wire logic tw_busy,
    input wire logic q1_phase
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_we_in_q4: assert property (dm_we |=> q1_phase)
        else $error("write strobe outside Q4");
    chk_we_one_clk: assert property (dm_we |=> !dm_we)
        else $error("write strobe longer than one clock");
    chk_phase_cycle: assert property (q1_phase ##1 !q1_phase |=> !q1_phase [*2] ##1 q1_phase)
        else $error("instruction cycle not four clocks");
    chk_clr_cause: assert property (prescaler_clr |-> dm_we && dm_addr == TIMER0_ADDR && $past(prescaler_assigned))
        else $error("prescaler clear without timer write");
    chk_clr_needed: assert property (dm_we && dm_addr == TIMER0_ADDR && $past(prescaler_assigned) |-> prescaler_clr)
        else $error("timer write left prescaler");
    chk_busy_holds: assert property (tw_busy && !tw_done |=> tw_busy)
        else $error("table write aborted");
    chk_daddr_held: assert property (!q1_phase && !$past(q1_phase) |-> $stable(dm_addr))
        else $error("data address moved mid cycle");
    chk_paddr_held: assert property (!q1_phase |-> $stable(pm_addr) && !pm_addr[0])
        else $error("program address moved mid cycle");
endmodule
bind cpuadd_core cpuadd_core_properties #(.TIMER0_ADDR(TIMER0_ADDR)) u_cpuadd_core_properties (
    .ref_clk(ref_clk), .rst(rst), .pm_addr(pm_addr), .dm_addr(dm_addr), .dm_we(dm_we),
    .prescaler_assigned(prescaler_assigned), .prescaler_clr(prescaler_clr),
    .tw_done(tw_done), .tw_busy(tw_busy), .q1_phase(q1_phase)
);
`default_nettype wire

// >>> dv/cpuadd_core_tb.sv
// self-checking bench for the add-execution core
`timescale 1ns/1ps
`default_nettype none
module cpuadd_core_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [20:0] pm_addr;
    logic [15:0] pm_rdata;
    logic [11:0] dm_addr;
    logic [7:0] dm_rdata, dm_wdata, reg_rdata;
    logic dm_we, prescaler_clr, tw_busy, q1_phase;
    logic tw_done = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    int n_fail = 0, tests_run = 0, cycles = 0, n_clr = 0;
    // word 8 is a lone second word, word 12 must be skipped by the taken branch
    logic [15:0] prog [15] = '{16'h0f10, 16'h0f15, 16'h0101, 16'h2620, 16'h2730, 16'h2681, 16'h26d6,
        16'h000c, 16'hf123, 16'h2440, 16'h0f80, 16'he001, 16'h0f77, 16'hef0d, 16'hf000};
    cpuadd_core u_cpuadd_core (.ref_clk(ref_clk), .rst(rst), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we),
        .port_b_pins(8'h0f), .prescaler_assigned(1'b1), .prescaler_clr(prescaler_clr),
        .tw_done(tw_done), .tw_busy(tw_busy), .q1_phase(q1_phase), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
    cpuadd_mem u_cpuadd_mem (.ref_clk(ref_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we));
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_we <= 1'b0;
    endtask
    // read data appear in the cycle after the strobe and hold until the next read strobe
    task automatic reg_rd(input logic [1:0] a, input logic [7:0] e);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_re <= 1'b0;
        @(negedge ref_clk);
        chk8(reg_rdata, e);
        @(posedge ref_clk);
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (prescaler_clr)
            n_clr++;
        if (cycles == 2000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial
    begin
        for (int i = 0; i < 256; i++)
            u_cpuadd_mem.pm[i] = (i < 15) ? prog[i] : 16'h0000;
        u_cpuadd_mem.dm[12'h020] = 8'hc2;
        u_cpuadd_mem.dm[12'h030] = 8'h55;
        u_cpuadd_mem.dm[12'h130] = 8'h01;
        u_cpuadd_mem.dm[12'h040] = 8'h5b;
        u_cpuadd_mem.dm[12'hf81] = 8'hff;
        u_cpuadd_mem.dm[12'hfd6] = 8'h00;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        reg_rd(2'h0, 8'h01);
        repeat (200) @(posedge ref_clk);
        chk8(u_cpuadd_mem.dm[12'h020], 8'he7);
        chk8(u_cpuadd_mem.dm[12'h130], 8'h26);
        chk8(u_cpuadd_mem.dm[12'h030], 8'h55);
        chk8(u_cpuadd_mem.dm[12'hf81], 8'h34);
        chk8(u_cpuadd_mem.dm[12'hfd6], 8'h25);
        chk8(u_cpuadd_mem.dm[12'h040], 8'h5b);
        chk8(n_clr[7:0], 8'h01);
        chk8({7'h00, tw_busy}, 8'h01);
        reg_rd(2'h1, 8'h00);
        reg_rd(2'h2, 8'h0d);
        reg_wr(2'h1, 8'hff);
        reg_wr(2'h0, 8'h00);
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        chk8({7'h00, q1_phase}, 8'h01);
        @(posedge ref_clk);
        reg_rd(2'h1, 8'h00);
        reg_rd(2'h0, 8'h00);
        tw_done <= 1'b1;
        @(posedge ref_clk);
        tw_done <= 1'b0;
        @(negedge ref_clk);
        chk8({7'h00, tw_busy}, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> dv/cpuadd_mem.sv
// program and data memory seen by the core
`timescale 1ns/1ps
`default_nettype none
module cpuadd_mem (
    input wire logic ref_clk,
    input wire logic [20:0] pm_addr,
    output logic [15:0] pm_rdata,
    input wire logic [11:0] dm_addr,
    output logic [7:0] dm_rdata,
    input wire logic [7:0] dm_wdata,
    input wire logic dm_we
);
    logic [15:0] pm [256];
    logic [7:0] dm [4096];
    // word index from the even byte address
    assign pm_rdata = pm[pm_addr[8:1]];
    assign dm_rdata = dm[dm_addr];
    always @(posedge ref_clk)
    begin
        if (dm_we)
            dm[dm_addr] <= dm_wdata;
    end
endmodule
`default_nettype wire
